// *** logic/hptt_top.v ***
// Spanning tree gating and host port tail tag insertion and removal
//
// Notes on behaviour
// RQ1: Tx, rx off and learning disabled means discarding: no traffic, no learning.
// RQ2: Discarding ports still deliver override static matches to the host.
// RQ3: Learning disabled allows a rapid flush of that port's table entries.
// RQ4: Tx, rx off with learning enabled: learn, only host traffic passes.
// RQ5: Tx, rx on with learning enabled: forward normally and learn.
// RQ6: Host sends nothing to discarding ports and drops override matches from them.
// RQ7: Host loads override static entries, e.g. BPDUs, for learning/forwarding ports.
// RQ8: Entries carry a 3-bit tree index; each port keeps state per tree.
// RQ9: Tail tag sits after payload, right before the 4-byte FCS.
// RQ10: Frames to the host port get exactly one ingress tag byte.
// RQ11: Tag bits 2:0 code ingress port, port 1 as 000 to port 7 as 110.
// RQ12: Tag bit 7 marks an inserted receive timestamp; bits 6:3 reserved zero.
// RQ13: Host appends a two-byte tag to each frame; bits 15:11 reserved.
// RQ14: The two-byte host tag is stripped before any egress transmission.
// RQ15: Lookup bit 10 set: ignore bits 9:0, use normal lookup.
// RQ16: Lookup clear: bits 6:0 forward mask ports 7..1, bits 8:7 queue.
// RQ17: Bit 9 set sends on selected ports despite tree transmit blocking.
// RQ18: Tagging applies on the host port only.
// RQ19: Exactly one port may enable tagging; off after reset.
// RQ20: FCS is recomputed after tag insertion or removal; here only after insertion, removal drops the host FCS without a new one.
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "hptt_regs.vh"

module hptt_top (
  input wire clk_i,
  input wire rst_i,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Per frame classification query from the fabric
  input wire cls_req_i,
  input wire [2:0] cls_port_i,
  input wire [2:0] cls_tree_i,
  input wire cls_to_host_i,
  input wire cls_from_host_i,
  input wire cls_ovr_match_i,
  output reg cls_done_o,
  output reg cls_fwd_o,
  output reg cls_learn_o,
  // Flush request to the lookup tables
  output reg flush_o,
  output reg [2:0] flush_port_o,
  // To-host stream: fabric bytes in, framed bytes out to the host MAC
  input wire th_valid_i,
  input wire [7:0] th_data_i,
  input wire th_last_i,
  input wire [2:0] th_port_i,
  input wire th_ts_i,
  output wire th_ready_o,
  output reg th_valid_o,
  output reg [7:0] th_data_o,
  output reg th_last_o,
  // From-host stream: host bytes in (with FCS), tag decoded and stripped
  input wire fh_valid_i,
  input wire [7:0] fh_data_i,
  input wire fh_last_i,
  output reg fh_valid_o,
  output reg [7:0] fh_data_o,
  output reg fh_last_o,
  output reg fh_tag_valid_o,
  output reg fh_lookup_o,
  output reg [6:0] fh_mask_o,
  output reg [1:0] fh_queue_o,
  output reg fh_override_o
);

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  reg [7:0] tagen_r;
  reg ts_en_r;
  reg [31:0] ctrl_rd;
  wire [2:0] host_port;
  wire host_ok;
  wire wb_req;
  wire tree_hit;
  wire [2:0] st_rdata;
  reg [5:0] st_raddr;
  reg [3:0] flush_cnt_r;
  reg rd_wait_r;

  function [3:0] ones8;
    input [7:0] v;
    integer k;
    begin
      ones8 = 4'h0;
      for (k = 0; k < 8; k = k + 1) begin
        ones8 = ones8 + {3'h0, v[k]};
      end
    end
  endfunction

  function [2:0] low_idx;
    input [7:0] v;
    integer k;
    begin
      low_idx = 3'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (v[k]) begin
          low_idx = k[2:0];
        end
      end
    end
  endfunction

  // Host port valid only when exactly one port enables tagging
  assign host_ok = (ones8(tagen_r) == 4'h1); // RQ19
  assign host_port = low_idx(tagen_r);
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign tree_hit = (wb_adr_i[7:6] == 2'b01);

  always @* begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[`HPTT_CTRL_TAGEN_LSB +: 8] = tagen_r;
    ctrl_rd[`HPTT_CTRL_HOST_LSB +: 3] = host_port;
    ctrl_rd[`HPTT_CTRL_HOST_LSB + 3] = host_ok;
    ctrl_rd[`HPTT_CTRL_TS_BIT] = ts_en_r;
  end

  // Tree state reads take one extra cycle through the memory register
  always @(posedge clk_i) begin
    if (rst_i) begin
      tagen_r <= 8'h00; // RQ19
      ts_en_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      rd_wait_r <= 1'b0;
    end else begin
      wb_ack_o <= 1'b0;
      if (rd_wait_r) begin
        rd_wait_r <= 1'b0;
        wb_ack_o <= 1'b1;
        wb_dat_o <= {29'h0, st_rdata};
      end else if (wb_req) begin
        if (tree_hit && !wb_we_i) begin
          rd_wait_r <= 1'b1;
        end else begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= 32'h0000_0000;
          case (wb_adr_i)
            `HPTT_OFF_CTRL: begin
              if (wb_we_i) begin
                if (wb_sel_i[0]) begin
                  tagen_r <= wb_dat_i[7:0];
                end
                if (wb_sel_i[2]) begin
                  ts_en_r <= wb_dat_i[`HPTT_CTRL_TS_BIT];
                end
              end else begin
                wb_dat_o <= ctrl_rd;
              end
            end
            `HPTT_OFF_STATUS: begin
              wb_dat_o <= {27'h0, flush_o, flush_cnt_r};
            end
            default: begin
              wb_dat_o <= 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Tree state memory, shared by bus and classifier
  // ----------------------------------------------------------------------------
  wire st_we;
  wire [5:0] st_baddr;
  // Only trees 0 and 1 fit the 8-bit bus window
  assign st_baddr = {2'b00, wb_adr_i[5:2]};
  assign st_we = wb_req && wb_we_i && tree_hit && wb_sel_i[0] && !rd_wait_r;

  always @* begin
    if (rd_wait_r || (wb_req && tree_hit)) begin
      st_raddr = st_baddr;
    end else begin
      st_raddr = {cls_tree_i, cls_port_i}; // RQ8
    end
  end

  hptt_state_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(st_we),
    .waddr_i(st_baddr),
    .wdata_i(wb_dat_i[2:0]),
    .raddr_i(st_raddr),
    .rdata_o(st_rdata)
  );

  // ----------------------------------------------------------------------------
  // Flush: a write to FLUSH, or learning being disabled by a state write
  // ----------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      flush_o <= 1'b0;
      flush_port_o <= 3'h0;
      flush_cnt_r <= 4'h0;
    end else if (flush_cnt_r != 4'h0) begin
      flush_cnt_r <= flush_cnt_r - 4'h1;
      flush_o <= (flush_cnt_r != 4'h1);
    end else if (wb_req && wb_we_i && !rd_wait_r &&
                 ((wb_adr_i == `HPTT_OFF_FLUSH) || (st_we && wb_dat_i[`HPTT_ST_LDIS]))) begin
      flush_o <= 1'b1; // RQ3
      flush_port_o <= (wb_adr_i == `HPTT_OFF_FLUSH) ? wb_dat_i[2:0] : wb_adr_i[4:2];
      flush_cnt_r <= `HPTT_FLUSH_CYCLES;
    end
  end

  // ----------------------------------------------------------------------------
  // Classifier: answer two cycles after a request made outside a bus tree access (memory latency)
  // ----------------------------------------------------------------------------
  reg cls_p_r;
  reg [2:0] cls_port_r;
  reg cls_th_r;
  reg cls_fh_r;
  reg cls_ovr_r;
  wire st_tx;
  wire st_rx;
  wire st_learn;

  assign st_tx = st_rdata[`HPTT_ST_TX];
  assign st_rx = st_rdata[`HPTT_ST_RX];
  assign st_learn = !st_rdata[`HPTT_ST_LDIS];

  always @(posedge clk_i) begin
    if (rst_i) begin
      cls_p_r <= 1'b0;
      cls_port_r <= 3'h0;
      cls_th_r <= 1'b0;
      cls_fh_r <= 1'b0;
      cls_ovr_r <= 1'b0;
      cls_done_o <= 1'b0;
      cls_fwd_o <= 1'b0;
      cls_learn_o <= 1'b0;
    end else begin
      cls_p_r <= cls_req_i && !(wb_req && tree_hit) && !rd_wait_r;
      cls_port_r <= cls_port_i;
      cls_th_r <= cls_to_host_i;
      cls_fh_r <= cls_from_host_i;
      cls_ovr_r <= cls_ovr_match_i;
      cls_done_o <= cls_p_r;
      if (cls_p_r) begin
        // Host port itself is never gated by tree state
        if (host_ok && cls_port_r == host_port) begin
          cls_fwd_o <= 1'b1;
          cls_learn_o <= 1'b1;
        end else if (st_tx && st_rx) begin
          cls_fwd_o <= 1'b1; // RQ5
          cls_learn_o <= st_learn;
        end else if (st_learn) begin
          cls_fwd_o <= cls_th_r || cls_fh_r; // RQ4
          cls_learn_o <= 1'b1;
        end else begin
          cls_fwd_o <= cls_th_r && cls_ovr_r; // RQ1 RQ2
          cls_learn_o <= 1'b0; // RQ1
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // To-host path: payload, optional timestamp, tag byte, fresh FCS
  // Incoming frame carries no FCS; timestamp bytes are part of its data.
  // ----------------------------------------------------------------------------
  localparam TH_DATA = 3'b001;
  localparam TH_TAG = 3'b010;
  localparam TH_FCS = 3'b100;
  reg [2:0] th_st_r;
  reg [7:0] th_tag_r;
  reg [1:0] th_fcnt_r;
  wire [31:0] th_fcs;
  wire th_take;
  wire th_crc_en;
  reg [7:0] th_byte;

  assign th_ready_o = (th_st_r == TH_DATA);
  assign th_take = th_valid_i && th_ready_o;

  always @* begin
    case (th_st_r)
      TH_TAG: th_byte = th_tag_r;
      default: th_byte = th_data_i;
    endcase
  end

  assign th_crc_en = th_take || (th_st_r == TH_TAG);

  hptt_fcs u_th_fcs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(th_st_r == TH_FCS && th_fcnt_r == 2'h3),
    .en_i(th_crc_en),
    .data_i(th_byte),
    .fcs_o(th_fcs)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      th_st_r <= TH_DATA;
      th_tag_r <= 8'h00;
      th_fcnt_r <= 2'h0;
      th_valid_o <= 1'b0;
      th_data_o <= 8'h00;
      th_last_o <= 1'b0;
    end else begin
      th_valid_o <= 1'b0;
      th_last_o <= 1'b0;
      case (th_st_r)
        TH_DATA: begin
          if (th_take) begin
            th_valid_o <= 1'b1;
            th_data_o <= th_data_i;
            if (th_last_i) begin
              if (host_ok) begin
                th_tag_r <= {th_ts_i && ts_en_r, 4'h0, th_port_i}; // RQ10 RQ11 RQ12
                th_st_r <= TH_TAG; // RQ9 RQ18
              end else begin
                th_st_r <= TH_FCS;
              end
              th_fcnt_r <= 2'h0;
            end
          end
        end
        TH_TAG: begin
          th_valid_o <= 1'b1;
          th_data_o <= th_tag_r;
          th_st_r <= TH_FCS;
        end
        TH_FCS: begin
          th_valid_o <= 1'b1;
          th_data_o <= th_fcs[8 * th_fcnt_r +: 8]; // RQ20
          th_fcnt_r <= th_fcnt_r + 2'h1;
          if (th_fcnt_r == 2'h3) begin
            th_last_o <= 1'b1;
            th_st_r <= TH_DATA;
          end
        end
        default: begin
          th_st_r <= TH_DATA;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // From-host path: hold last six bytes (tag + FCS), emit the rest, then decode
  // the tag and drop the host FCS; the egress MAC appends a new FCS.
  // ----------------------------------------------------------------------------
  reg [47:0] fh_sh_r;
  reg [2:0] fh_fill_r;
  wire [15:0] fh_tag;

  assign fh_tag = {fh_sh_r[15:8], fh_sh_r[7:0]} & 16'h07FF; // RQ13

  always @(posedge clk_i) begin
    if (rst_i) begin
      fh_sh_r <= 48'h0;
      fh_fill_r <= 3'h0;
      fh_valid_o <= 1'b0;
      fh_data_o <= 8'h00;
      fh_last_o <= 1'b0;
      fh_tag_valid_o <= 1'b0;
      fh_lookup_o <= 1'b0;
      fh_mask_o <= 7'h00;
      fh_queue_o <= 2'h0;
      fh_override_o <= 1'b0;
    end else begin
      fh_valid_o <= 1'b0;
      fh_last_o <= 1'b0;
      fh_tag_valid_o <= 1'b0;
      if (fh_valid_i) begin
        fh_sh_r <= {fh_data_i, fh_sh_r[47:8]};
        if (fh_fill_r == 3'h6) begin
          fh_valid_o <= 1'b1; // RQ14
          fh_data_o <= fh_sh_r[7:0];
        end else begin
          fh_fill_r <= fh_fill_r + 3'h1;
        end
        if (fh_last_i) begin
          fh_fill_r <= 3'h0;
          fh_last_o <= (fh_fill_r == 3'h6);
        end
      end
      if (fh_last_o || (fh_valid_i && fh_last_i && fh_fill_r != 3'h6)) begin
        fh_tag_valid_o <= host_ok; // RQ18
        fh_lookup_o <= fh_tag[`HPTT_ETAG_LOOKUP]; // RQ15
        fh_mask_o <= fh_tag[`HPTT_ETAG_LOOKUP] ? 7'h00 : fh_tag[6:0]; // RQ16
        fh_queue_o <= fh_tag[`HPTT_ETAG_LOOKUP] ? 2'h0 : fh_tag[`HPTT_ETAG_PRI_LSB +: 2];
        fh_override_o <= !fh_tag[`HPTT_ETAG_LOOKUP] && fh_tag[`HPTT_ETAG_OVR]; // RQ17
      end
    end
  end

endmodule

`default_nettype wire

// *** logic/hptt_regs.vh ***
// Register offsets, field positions, reset values and timing counts for the host port tail tag block
`ifndef HPTT_REGS_VH
`define HPTT_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define HPTT_OFF_CTRL 8'h00
`define HPTT_OFF_FLUSH 8'h04
`define HPTT_OFF_STATUS 8'h08
`define HPTT_OFF_TREE_BASE 8'h40

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define HPTT_CTRL_TAGEN_LSB 0
`define HPTT_CTRL_HOST_LSB 8
`define HPTT_CTRL_TS_BIT 16
`define HPTT_CTRL_RST 32'h0000_0000

// ----------------------------------------------------------------------------
// Per tree port state word: one bit triple per port
// ----------------------------------------------------------------------------
`define HPTT_ST_TX 0
`define HPTT_ST_RX 1
`define HPTT_ST_LDIS 2
`define HPTT_ST_RST 3'h4

// ----------------------------------------------------------------------------
// Tag layouts, frame tail byte counts and flush length
// ----------------------------------------------------------------------------
`define HPTT_ITAG_TS 7
`define HPTT_ETAG_LOOKUP 10
`define HPTT_ETAG_OVR 9
`define HPTT_ETAG_PRI_LSB 7
`define HPTT_FCS_BYTES 4
`define HPTT_TS_BYTES 4
`define HPTT_FLUSH_CYCLES 4'h8

`endif

// *** logic/hptt_state_mem.v ***
// Per tree, per port spanning tree state memory with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "hptt_regs.vh"

module hptt_state_mem (
  input wire clk_i,
  input wire rst_i,
  input wire we_i,
  input wire [5:0] waddr_i,
  input wire [2:0] wdata_i,
  input wire [5:0] raddr_i,
  output reg [2:0] rdata_o
);

  // 8 trees x 8 ports; index = {tree, port}
  reg [2:0] mem_r [0:63];
  reg [6:0] init_r;

  // ----------------------------------------------------------------------------
  // Reset walk: every entry starts discarding, one per cycle
  // ----------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      init_r <= 7'h00;
    end else if (!init_r[6]) begin
      init_r <= init_r + 7'h01;
    end
  end

  always @(posedge clk_i) begin
    if (!init_r[6]) begin
      mem_r[init_r[5:0]] <= `HPTT_ST_RST;
    end else if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 3'h0;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule

`default_nettype wire

// *** logic/hptt_fcs.v ***
// Ethernet CRC-32 accumulator, one byte per cycle
`timescale 1ns/1ns
`default_nettype none

module hptt_fcs (
  input wire clk_i,
  input wire rst_i,
  input wire clear_i,
  input wire en_i,
  input wire [7:0] data_i,
  output wire [31:0] fcs_o
);

  reg [31:0] crc_r;

  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer k;
    reg [31:0] t;
    begin
      t = c;
      for (k = 0; k < 8; k = k + 1) begin
        if (t[0] ^ d[k]) begin
          t = (t >> 1) ^ 32'hEDB8_8320;
        end else begin
          t = t >> 1;
        end
      end
      crc_byte = t;
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      crc_r <= 32'hFFFF_FFFF;
    end else if (en_i) begin
      crc_r <= crc_byte(crc_r, data_i);
    end
  end

  // Complemented, least significant byte goes on the wire first
  assign fcs_o = ~crc_r;

endmodule

`default_nettype wire

// *** bench/hptt_props.sv ***
// Port level assertions for the tail tag and tree state block
`timescale 1ns/1ns
`default_nettype none
module hptt_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cls_req_i,
  input wire logic cls_done_o,
  input wire logic flush_o,
  input wire logic [2:0] flush_port_o,
  input wire logic th_valid_i,
  input wire logic th_ready_o,
  input wire logic th_last_i,
  input wire logic th_last_o,
  input wire logic fh_last_o,
  input wire logic fh_tag_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  a_ack_cause: assert property (wb_ack_o |-> wb_cyc_i && $past(wb_stb_i))
    else $error("ack without request");
  a_class_latency: assert property (cls_done_o |-> $past(cls_req_i, 2))
    else $error("classify answer at wrong cycle");
  a_tail_length: assert property (th_valid_i && th_ready_o && th_last_i |-> ##[5:6] th_last_o)
    else $error("tag and check bytes not closing frame");
  a_tail_gap: assert property (th_valid_i && th_ready_o && th_last_i |=> !th_ready_o [*4])
    else $error("input taken while tail is emitted");
  a_last_once: assert property (th_last_o |=> !th_last_o)
    else $error("frame end longer than one byte");
  a_decode_pulse: assert property (fh_last_o |=> fh_tag_valid_o)
    else $error("host tag decode missing after frame");
  a_decode_cause: assert property (fh_tag_valid_o |-> $past(fh_last_o))
    else $error("host tag decode without frame end");
  a_flush_span: assert property ($rose(flush_o) |-> flush_o [*8] ##1 !flush_o)
    else $error("flush pulse length wrong");
  a_flush_port: assert property (flush_o && $past(flush_o) |-> $stable(flush_port_o))
    else $error("flush port moved during flush");
endmodule
bind hptt_top hptt_props u_props (.*);
`default_nettype wire

// *** bench/hptt_host_mac.sv ***
// Host processor MAC model on the tagged host port
`timescale 1ns/1ns
`default_nettype none
module hptt_host_mac (
  input wire logic clk_i,
  output logic fh_valid_o,
  output logic [7:0] fh_data_o,
  output logic fh_last_o,
  input wire logic th_valid_i,
  input wire logic [7:0] th_data_i,
  input wire logic th_last_i
);
  logic [7:0] rx_q[$];
  int rx_last = 0;
  initial begin
    fh_valid_o = 1'b0;
    fh_data_o = 8'h00;
    fh_last_o = 1'b0;
  end
  // Reflected CRC-32, sent low byte first
  function automatic logic [31:0] fcs(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    foreach (b[k])
      for (int i = 0; i < 8; i++)
        c = (c >> 1) ^ ((c[0] ^ b[k][i]) ? 32'hEDB8_8320 : 32'h0000_0000);
    return ~c;
  endfunction
  task automatic send(input logic [7:0] p[$], input logic [15:0] tag);
    logic [31:0] f;
    p.push_back(tag[7:0]);
    p.push_back(tag[15:8]);
    f = fcs(p);
    for (int i = 0; i < 4; i++)
      p.push_back(f[8*i+:8]);
    foreach (p[k]) begin
      @(posedge clk_i);
      fh_valid_o <= 1'b1;
      fh_data_o <= p[k];
      fh_last_o <= (k == p.size() - 1);
    end
    @(posedge clk_i);
    fh_valid_o <= 1'b0;
    fh_last_o <= 1'b0;
    // Idle line must not look like a repeat of the last byte
    fh_data_o <= ~p[p.size() - 1];
  endtask
  always @(posedge clk_i) begin
    if (th_valid_i) begin
      rx_q.push_back(th_data_i);
      if (th_last_i)
        rx_last = rx_q.size();
    end
  end
endmodule
`default_nettype wire

// *** bench/hptt_top_tb.sv ***
// Self-checking bench for the tail tag and tree state block
`timescale 1ns/1ns
`default_nettype none
`include "hptt_regs.vh"
module hptt_top_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, cls_req_i = 0;
  logic cls_to_host_i = 0, cls_from_host_i = 0, cls_ovr_match_i = 0, th_valid_i = 0, th_last_i = 0, th_ts_i = 0;
  logic [7:0] wb_adr_i = 8'h00, th_data_i = 8'h00, fh_data_i;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, rd;
  logic [2:0] cls_port_i = 3'h0, cls_tree_i = 3'h0, th_port_i = 3'h0;
  logic fh_valid_i, fh_last_i;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, cls_done_o, cls_fwd_o, cls_learn_o, flush_o, th_ready_o, th_valid_o, th_last_o;
  wire fh_valid_o, fh_last_o, fh_tag_valid_o, fh_lookup_o, fh_override_o;
  wire [2:0] flush_port_o;
  wire [7:0] th_data_o, fh_data_o;
  wire [6:0] fh_mask_o;
  wire [1:0] fh_queue_o;
  int error_cnt = 0, check_count = 0, n;
  logic [7:0] out_q[$];
  always #2 clk_i = ~clk_i;
  hptt_top dut (.*);
  hptt_host_mac u_host (.clk_i(clk_i), .fh_valid_o(fh_valid_i), .fh_data_o(fh_data_i), .fh_last_o(fh_last_i),
    .th_valid_i(th_valid_o), .th_data_i(th_data_o), .th_last_i(th_last_o));
  always @(posedge clk_i)
    if (fh_valid_o) out_q.push_back(fh_data_o);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input string what);
    error_cnt++;
    $display("mismatch %s expected answer seen timeout", what);
    complete_run();
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (wb_ack_o !== 1'b1) hang("bus ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic cls(input logic [2:0] t, input logic h, f, o, ef, el);
    @(posedge clk_i);
    cls_req_i <= 1'b1;
    cls_port_i <= 3'h1;
    cls_tree_i <= t;
    cls_to_host_i <= h;
    cls_from_host_i <= f;
    cls_ovr_match_i <= o;
    @(posedge clk_i);
    cls_req_i <= 1'b0;
    @(negedge clk_i);
    for (n = 0; n < 8 && cls_done_o !== 1'b1; n++) @(negedge clk_i);
    if (cls_done_o !== 1'b1) hang("classify");
    chk("forward", ef, cls_fwd_o);
    chk("learn", el, cls_learn_o);
  endtask
  task automatic tohost(input logic [2:0] prt, input logic ts, tg, input logic [7:0] tb);
    logic [7:0] p[$];
    logic [7:0] e[$];
    logic [31:0] f;
    p = '{8'h01, 8'h80, 8'hFE, 8'h7F, 8'h55, 8'hAA};
    e = p;
    if (tg) e.push_back(tb);
    f = u_host.fcs(e);
    for (int i = 0; i < 4; i++)
      e.push_back(f[8*i+:8]);
    u_host.rx_q.delete();
    u_host.rx_last = 0;
    @(posedge clk_i);
    foreach (p[k]) begin
      th_valid_i <= 1'b1;
      th_data_i <= p[k];
      th_last_i <= (k == p.size() - 1);
      th_port_i <= prt;
      th_ts_i <= ts;
      for (n = 0; n < 20; n++) begin
        @(posedge clk_i);
        if (th_ready_o === 1'b1) break;
      end
      if (th_ready_o !== 1'b1) hang("fabric ready");
    end
    th_valid_i <= 1'b0;
    th_last_i <= 1'b0;
    for (n = 0; n < 40 && u_host.rx_last == 0; n++) @(negedge clk_i);
    if (u_host.rx_last == 0) hang("host frame end");
    chk("host frame length", e.size(), u_host.rx_last);
    foreach (e[k])
      chk("host frame byte", e[k], u_host.rx_q[k]);
  endtask
  task automatic fromhost(input logic [15:0] tag, input logic lk, ov, input logic [1:0] q, input logic [6:0] m);
    logic [7:0] p[$];
    p = '{8'h5A, 8'hA5, 8'h00, 8'hFF, 8'h3C, 8'hC3, 8'h81, 8'h7E};
    out_q.delete();
    u_host.send(p, tag);
    @(negedge clk_i);
    for (n = 0; n < 20 && fh_tag_valid_o !== 1'b1; n++) @(negedge clk_i);
    if (fh_tag_valid_o !== 1'b1) hang("tag decode");
    chk("stripped length", p.size(), out_q.size());
    foreach (p[k])
      chk("stripped byte", p[k], out_q[k]);
    chk("lookup", lk, fh_lookup_o);
    if (!lk) begin
      chk("override", ov, fh_override_o);
      chk("queue", q, fh_queue_o);
      chk("mask", m, fh_mask_o);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (70) @(posedge clk_i);
    wb(1'b0, `HPTT_OFF_CTRL, 32'h0000_0000);
    chk("control reset", `HPTT_CTRL_RST, rd);
    wb(1'b0, `HPTT_OFF_TREE_BASE + 8'h04, 32'h0000_0000);
    chk("state reset", 32'h0000_0004, rd);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    $display("test registers done");
    cls(3'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    cls(3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    cls(3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    wb(1'b1, `HPTT_OFF_TREE_BASE + 8'h04, 32'h0000_0000);
    cls(3'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    cls(3'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    cls(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    wb(1'b1, `HPTT_OFF_TREE_BASE + 8'h04, 32'h0000_0003);
    wb(1'b0, `HPTT_OFF_TREE_BASE + 8'h04, 32'h0000_0000);
    chk("state readback", 32'h0000_0003, rd);
    cls(3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cls(3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wb(1'b1, `HPTT_OFF_TREE_BASE + 8'h24, 32'h0000_0003);
    cls(3'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("test tree states done");
    wb(1'b1, `HPTT_OFF_FLUSH, 32'h0000_0002);
    for (n = 0; n < 10 && flush_o !== 1'b1; n++) @(negedge clk_i);
    if (flush_o !== 1'b1) hang("flush start");
    chk("flush port", 32'h0000_0002, flush_port_o);
    repeat (12) @(posedge clk_i);
    wb(1'b0, `HPTT_OFF_STATUS, 32'h0000_0000);
    chk("flush idle", 32'h0000_0000, rd);
    wb(1'b1, `HPTT_OFF_TREE_BASE + 8'h0C, 32'h0000_0004);
    for (n = 0; n < 10 && flush_o !== 1'b1; n++) @(negedge clk_i);
    if (flush_o !== 1'b1) hang("learn off flush");
    chk("learn off flush port", 32'h0000_0003, flush_port_o);
    repeat (12) @(posedge clk_i);
    $display("test flush done");
    wb(1'b1, `HPTT_OFF_CTRL, 32'h0001_0080);
    wb(1'b0, `HPTT_OFF_CTRL, 32'h0000_0000);
    chk("host select", 32'h0001_0F80, rd);
    tohost(3'h3, 1'b1, 1'b1, 8'h83);
    tohost(3'h6, 1'b0, 1'b1, 8'h06);
    fromhost(16'h0400, 1'b1, 1'b0, 2'h0, 7'h00);
    fromhost(16'h07FF, 1'b1, 1'b0, 2'h0, 7'h00);
    fromhost(16'h03A5, 1'b0, 1'b1, 2'h3, 7'h25);
    fromhost(16'h0142, 1'b0, 1'b0, 2'h2, 7'h42);
    wb(1'b1, `HPTT_OFF_CTRL, 32'h0000_0080);
    tohost(3'h0, 1'b1, 1'b1, 8'h00);
    wb(1'b1, `HPTT_OFF_CTRL, 32'h0000_0081);
    tohost(3'h2, 1'b0, 1'b0, 8'h00);
    $display("test tail tags done");
    complete_run();
  end
endmodule
`default_nettype wire
